//--- src/serial_port_pkg.sv
// constants, types and encodings for the three-wire serial port with port A mux
// assumes a single 100 MHz system clock and active-low asynchronous reset
package serial_port_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SHIFT_COUNT = 8;
   localparam logic [3:0] SHIFT_LAST = 4'h8;
   localparam logic [3:0] SHIFT_ZERO = 4'h0;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   // clock source codes
   localparam logic [1:0] SRC_SLAVE = 2'h0;
   localparam logic [1:0] SRC_QUARTER = 2'h1;
   localparam logic [1:0] SRC_HALF = 2'h2;
   localparam logic [1:0] SRC_FULL = 2'h3;
   // frequency output codes
   localparam logic [1:0] FOUT_1HZ = 2'h0;
   localparam logic [1:0] FOUT_2KHZ = 2'h1;
   localparam logic [1:0] FOUT_SYS = 2'h2;
   localparam logic [1:0] FOUT_CPU = 2'h3;
   // port bit positions
   localparam int PB0 = 0;
   localparam int PB1 = 1;
   localparam int PB2 = 2;
   localparam int PB3 = 3;
   localparam int PB4 = 4;
   localparam int PB5 = 5;

   typedef struct packed {
      logic [1:0] clock_source;
      logic shift_edge_select;
      logic bit_order_select;
      logic output_retime_mode;
   } serial_cfg_t;

   typedef struct packed {
      logic clock_pin_select;
      logic counter_wave_pin_select;
      logic dataout_reset_pin_select;
      logic freq_pin_select_bit2;
      logic freq_pin_select_bit5;
      logic status_pin_select;
   } mux_cfg_t;

   typedef struct packed {
      logic cpu_clock;
      logic system_clock_source;
      logic tap_2khz;
      logic tap_1hz;
      logic tap_8khz;
   } freq_src_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_DONE = 3'b100
   } shift_state_t;
endpackage

//--- src/data_fifo.sv
// parameterised first-in first-out buffer with valid/ready on both sides
// assumes one clock and active-low asynchronous reset
`timescale 1ns/1ps
module data_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;
   logic push;
   logic pop;

   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= next_count;
         // ready is registered so the port comes straight from a flop
         in_ready <= (next_count != (AW+1)'(DEPTH));
      end
   end

   fifo_bound_a: assert property (@(posedge clk) disable iff (!resetn)
      count <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule // data_fifo

//--- src/clock_edge_gen.sv
// master shift-clock generator from the three prescaler rates
// assumes one clock; produces a registered shift clock and its edge pulses
`timescale 1ns/1ps
module clock_edge_gen (
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [1:0] clock_source,
   output logic sclk,
   output logic rise,
   output logic fall
);
   import serial_port_pkg::*;

   logic [1:0] div;
   logic tick;

   // tick marks a toggle of the shift clock
   always_comb begin
      unique case (clock_source)
         SRC_FULL: tick = 1'b1;
         SRC_HALF: tick = div[0];
         SRC_QUARTER: tick = (div == 2'h3);
         SRC_SLAVE: tick = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div <= 2'h0;
      end else if (!run) begin
         div <= 2'h0;
      end else begin
         div <= div + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclk <= 1'b0;
      end else if (!run) begin
         sclk <= 1'b0;
      end else if (tick) begin
         sclk <= ~sclk;
      end
   end

   assign rise = run && tick && !sclk;
   assign fall = run && tick && sclk;

   idle_low_a: assert property (@(posedge clk) disable iff (!resetn)
      !run |=> !sclk) else $error("shift clock not low while idle");
endmodule // clock_edge_gen

//--- src/serial_port.sv
// three-wire serial port with port A output multiplexing
// assumes synchronous pin inputs, one 100 MHz clock, active-low async reset
//
// What this block does
// - bit1 is input, latch, counter wave or shift clock by its selects.
// - bit2 drives latch, frequency output or serial data by its selects.
// - bit2 output with both selects: high in reset, 8kHz after, low asleep.
// - bit2 input with both selects and strap pattern: driven high only in reset.
// - bit3 drives latch or ready/chip-select status by its select.
// - bit5 drives latch or chosen frequency: cpu, system, 2kHz or 1Hz.
// - cpu clock is rc clock, or bit1 input clock when external clock used.
// - received bits from bit0 fill shift register, read as low/high nibbles.
// - loaded register shifts out on bit2 while input shifts in together.
// - master uses full, half or quarter rate; slave clock comes on bit1.
// - reset gives slave, start and status clear, lsb first, negative edge.
// - start allows eight shifts, then interrupt and start clears itself.
// - slave ignores clock while start low; uses only next eight edges.
// - bit3 status output equals start or status.
// - master drives shift clock on bit1 only while start; else zero.
// - last falling edge sets done request; next start write clears; maskable.
// - sample edge chosen by edge select; order chosen by bit order select.
// - source codes 00 slave, 01 quarter, 10 half, 11 full.
// - mode 0 data on shift edge; mode 1 retimed to rising edges.
`timescale 1ns/1ps
module serial_port (
   input wire logic CLK_SYS,
   input wire logic RESETN,
   input wire logic SLEEP,
   input wire logic EXT_CLOCK_USED,
   input wire logic RC_CLOCK,
   input wire logic PRESCALER_2KHZ,
   input wire logic PRESCALER_1HZ,
   input wire logic PRESCALER_8KHZ,
   input wire logic COUNTER_WAVE,
   input wire logic [1:0] FREQ_SELECT,
   input wire serial_port_pkg::serial_cfg_t CFG,
   input wire serial_port_pkg::mux_cfg_t MUX,
   input wire logic [5:0] PIN_DIRECTION,
   input wire logic [5:0] GENERAL_OUTPUT_LATCH,
   input wire logic START_WRITE,
   input wire logic START_VALUE,
   input wire logic STATUS,
   input wire logic IRQ_MASK,
   input wire logic DATA_WRITE,
   input wire logic [7:0] DATA_IN,
   input wire logic TX_VALID,
   output logic TX_READY,
   input wire logic [7:0] TX_DATA,
   output logic RX_VALID,
   input wire logic RX_READY,
   output logic [7:0] RX_DATA,
   input wire logic [5:0] PIN_IN,
   output logic [5:0] PIN_OUT,
   output logic [5:0] PIN_OE,
   output logic [3:0] DATA_LOW,
   output logic [3:0] DATA_HIGH,
   output logic START,
   output logic TRANSFER_DONE_IRQ
);
   import serial_port_pkg::*;

   shift_state_t state;
   logic [7:0] shreg;
   logic [3:0] count;
   logic start_q;
   logic irq_pend;
   logic serial_out;
   logic slave_prev;
   logic m_sclk;
   logic m_rise;
   logic m_fall;
   logic rise;
   logic fall;
   logic sample_edge;
   logic drive_edge;
   logic is_master;
   logic cpu_clock;
   logic freq_out;
   logic [5:0] next_pin_out;
   logic [5:0] next_pin_oe;
   logic fifo_out_valid;
   logic fifo_pop;
   logic [7:0] fifo_out_data;
   logic [7:0] rx_word;
   logic rx_push;

   // pick the bit leaving the register by bit order
   function automatic logic out_bit(input logic [7:0] v, input logic msb);
      return msb ? v[7] : v[0];
   endfunction

   assign is_master = (CFG.clock_source != SRC_SLAVE);
   assign cpu_clock = EXT_CLOCK_USED ? PIN_IN[PB1] : RC_CLOCK;

   clock_edge_gen u_clk (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .run(is_master && start_q),
      .clock_source(CFG.clock_source),
      .sclk(m_sclk),
      .rise(m_rise),
      .fall(m_fall)
   );

   // slave clock edge detect on the synchronous pin input
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         slave_prev <= 1'b0;
      end else begin
         slave_prev <= PIN_IN[PB1];
      end
   end

   // edges outside start are ignored
   assign rise = start_q && (is_master ? m_rise : (PIN_IN[PB1] && !slave_prev));
   assign fall = start_q && (is_master ? m_fall : (!PIN_IN[PB1] && slave_prev));
   assign sample_edge = CFG.shift_edge_select ? rise : fall;
   assign drive_edge = CFG.output_retime_mode ? rise : sample_edge;

   // loaded words are taken from the transmit buffer at start
   data_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .in_valid(TX_VALID),
      .in_ready(TX_READY),
      .in_data(TX_DATA),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );
   assign fifo_pop = START_WRITE && START_VALUE && (state == ST_IDLE) && !DATA_WRITE;

   // start bit and shift sequencing
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         state <= ST_IDLE;
         start_q <= 1'b0;
         count <= SHIFT_ZERO;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (START_WRITE && START_VALUE) begin
                  start_q <= 1'b1;
                  count <= SHIFT_ZERO;
                  state <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (sample_edge) begin
                  count <= count + 4'h1;
               end
               if (fall && count == SHIFT_LAST - 4'h1 && !CFG.shift_edge_select) begin
                  start_q <= 1'b0;
                  state <= ST_DONE;
               end else if (fall && count == SHIFT_LAST) begin
                  start_q <= 1'b0;
                  state <= ST_DONE;
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // shift register: load, shift in and out on the same register
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         shreg <= DATA_RESET;
      end else if (DATA_WRITE) begin
         shreg <= DATA_IN;
      end else if (fifo_pop && fifo_out_valid) begin
         shreg <= fifo_out_data;
      end else if (sample_edge) begin
         if (CFG.bit_order_select) begin
            shreg <= {shreg[6:0], PIN_IN[PB0]};
         end else begin
            shreg <= {PIN_IN[PB0], shreg[7:1]};
         end
      end
   end

   // output data bit, direct or retimed
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         serial_out <= 1'b0;
      end else if (!start_q || !CFG.output_retime_mode) begin
         // direct mode follows the register, so the loaded bit shows right after start
         serial_out <= out_bit(shreg, CFG.bit_order_select);
      end else if (drive_edge) begin
         serial_out <= out_bit(shreg, CFG.bit_order_select);
      end
   end

   // done request: set wins over a start write clear
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         irq_pend <= 1'b0;
      end else if (state == ST_DONE) begin
         irq_pend <= 1'b1;
      end else if (START_WRITE) begin
         irq_pend <= 1'b0;
      end
   end

   // received word pushed to the receive side
   assign rx_push = (state == ST_DONE);
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         RX_VALID <= 1'b0;
         rx_word <= DATA_RESET;
      end else if (rx_push) begin
         RX_VALID <= 1'b1;
         rx_word <= shreg;
      end else if (RX_READY) begin
         RX_VALID <= 1'b0;
      end
   end
   assign RX_DATA = rx_word;

   // frequency output choice
   always_comb begin
      unique case (FREQ_SELECT)
         FOUT_CPU: freq_out = cpu_clock;
         FOUT_SYS: freq_out = CLK_SYS;
         FOUT_2KHZ: freq_out = PRESCALER_2KHZ;
         FOUT_1HZ: freq_out = PRESCALER_1HZ;
      endcase
   end

   // pin multiplexing
   always_comb begin
      next_pin_out = 6'h00;
      next_pin_oe = 6'h00;
      next_pin_out[PB0] = GENERAL_OUTPUT_LATCH[PB0];
      next_pin_oe[PB0] = PIN_DIRECTION[PB0];
      next_pin_oe[PB1] = PIN_DIRECTION[PB1];
      if (MUX.clock_pin_select) begin
         next_pin_out[PB1] = is_master ? m_sclk : 1'b0;
      end else if (MUX.counter_wave_pin_select) begin
         next_pin_out[PB1] = COUNTER_WAVE;
      end else begin
         next_pin_out[PB1] = GENERAL_OUTPUT_LATCH[PB1];
      end
      next_pin_oe[PB2] = PIN_DIRECTION[PB2];
      if (MUX.dataout_reset_pin_select && MUX.freq_pin_select_bit2) begin
         next_pin_out[PB2] = SLEEP ? 1'b0 : PRESCALER_8KHZ;
      end else if (MUX.freq_pin_select_bit2) begin
         next_pin_out[PB2] = freq_out;
      end else if (MUX.dataout_reset_pin_select) begin
         next_pin_out[PB2] = serial_out;
      end else begin
         next_pin_out[PB2] = GENERAL_OUTPUT_LATCH[PB2];
      end
      next_pin_oe[PB3] = PIN_DIRECTION[PB3];
      next_pin_out[PB3] = MUX.status_pin_select ? (start_q || STATUS)
                                                : GENERAL_OUTPUT_LATCH[PB3];
      next_pin_oe[PB5] = PIN_DIRECTION[PB5];
      next_pin_out[PB5] = MUX.freq_pin_select_bit5 ? freq_out : GENERAL_OUTPUT_LATCH[PB5];
   end

   // registered pins; during reset bit2 is driven high whatever its selects are
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         PIN_OUT <= 6'h04;
         PIN_OE <= 6'h04;
      end else begin
         PIN_OUT <= next_pin_out;
         PIN_OE <= next_pin_oe;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         DATA_LOW <= 4'h0;
         DATA_HIGH <= 4'h0;
         START <= 1'b0;
         TRANSFER_DONE_IRQ <= 1'b0;
      end else begin
         DATA_LOW <= shreg[3:0];
         DATA_HIGH <= shreg[7:4];
         START <= start_q;
         TRANSFER_DONE_IRQ <= irq_pend && !IRQ_MASK;
      end
   end

   sequence start_req_s;
      START_WRITE && START_VALUE && state == ST_IDLE;
   endsequence

   start_sets_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      start_req_s |=> start_q ##1 START) else $error("start not raised");
   status_or_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      PIN_DIRECTION[PB3] && MUX.status_pin_select |=> PIN_OUT[PB3] == $past(start_q || STATUS))
      else $error("status pin not start or status");
   sclk_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      !start_q |-> !m_sclk) else $error("shift clock active without start");
   slave_ignore_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      !start_q && !DATA_WRITE && !fifo_pop |=> shreg == $past(shreg))
      else $error("edge used while idle");
   count_bound_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      count <= SHIFT_LAST) else $error("more than eight shifts");
   done_irq_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      state == ST_DONE |=> irq_pend) else $error("done request not set");
   mask_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      IRQ_MASK |=> !TRANSFER_DONE_IRQ) else $error("masked request shown");
   nibble_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      1'b1 |=> {DATA_HIGH, DATA_LOW} == $past(shreg)) else $error("nibbles mismatch");
   cpu_clk_a: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      !EXT_CLOCK_USED |-> cpu_clock == RC_CLOCK) else $error("cpu clock wrong");
endmodule // serial_port

//--- dv/serial_master_model.sv
// external serial master model: shift clock on bit1, data on bit0, captures bit2
// assumes the bench feeds it the resolved bit2 pin level and calls frame
`timescale 1ns/1ps
module serial_master_model (
   input wire logic clk,
   input wire logic sout,
   output logic sclk,
   output logic sdata
);
   logic last;
   initial begin
      sclk = 1'b0;
      sdata = 1'b1;
      last = 1'b1;
   end
   // one frame of eight clocks; clock stands low outside frames
   task automatic frame(input logic [7:0] tx, input logic msb, output logic [7:0] got);
      int k;
      int b;
      got = 8'h00;
      for (k = 0; k < 8; k++) begin
         b = msb ? 7 - k : k;
         repeat (2) @(negedge clk);
         sdata = tx[b];
         last = tx[b];
         repeat (2) @(negedge clk);
         got[b] = sout;
         sclk = 1'b1;
         repeat (4) @(negedge clk);
         sclk = 1'b0;
      end
      repeat (2) @(negedge clk);
      // released line shows the inverse of the last bit
      sdata = ~last;
   endtask
endmodule // serial_master_model

//--- dv/serial_port_bench.sv
// self-checking bench for the serial port and its port A multiplexing
// assumes the master model drives bits 0 and 1 of the pins
`timescale 1ns/1ps
module serial_port_bench;
   import serial_port_pkg::*;
   logic CLK_SYS, RESETN, SLEEP, EXT_CLOCK_USED, RC_CLOCK, COUNTER_WAVE;
   logic PRESCALER_2KHZ, PRESCALER_1HZ, PRESCALER_8KHZ;
   logic [1:0] FREQ_SELECT;
   serial_cfg_t CFG;
   mux_cfg_t MUX;
   logic [5:0] PIN_DIRECTION, GENERAL_OUTPUT_LATCH, PIN_IN, PIN_OUT, PIN_OE, ext;
   logic START_WRITE, START_VALUE, STATUS, IRQ_MASK, DATA_WRITE, TX_VALID, TX_READY;
   logic RX_VALID, RX_READY, START, TRANSFER_DONE_IRQ, sclk_m, sdata_m;
   logic [7:0] DATA_IN, TX_DATA, RX_DATA;
   logic [3:0] DATA_LOW, DATA_HIGH, pin_rest;
   int error_cnt = 0;
   int total_checks = 0;
   logic [7:0] tx_q[$];
   int i, n, w;

   // bit0 carries only the model's serial data while the port is in use
   assign ext = {pin_rest, sclk_m, sdata_m};
   assign PIN_IN = (PIN_OE & PIN_OUT) | (~PIN_OE & ext);

   serial_port u_serial_port (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .SLEEP(SLEEP),
      .EXT_CLOCK_USED(EXT_CLOCK_USED), .RC_CLOCK(RC_CLOCK), .PRESCALER_2KHZ(PRESCALER_2KHZ),
      .PRESCALER_1HZ(PRESCALER_1HZ), .PRESCALER_8KHZ(PRESCALER_8KHZ),
      .COUNTER_WAVE(COUNTER_WAVE), .FREQ_SELECT(FREQ_SELECT), .CFG(CFG), .MUX(MUX),
      .PIN_DIRECTION(PIN_DIRECTION), .GENERAL_OUTPUT_LATCH(GENERAL_OUTPUT_LATCH),
      .START_WRITE(START_WRITE), .START_VALUE(START_VALUE), .STATUS(STATUS),
      .IRQ_MASK(IRQ_MASK), .DATA_WRITE(DATA_WRITE), .DATA_IN(DATA_IN),
      .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA), .RX_VALID(RX_VALID),
      .RX_READY(RX_READY), .RX_DATA(RX_DATA), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
      .PIN_OE(PIN_OE), .DATA_LOW(DATA_LOW), .DATA_HIGH(DATA_HIGH), .START(START),
      .TRANSFER_DONE_IRQ(TRANSFER_DONE_IRQ));
   serial_master_model u_serial_master_model (.clk(CLK_SYS), .sout(PIN_IN[2]),
      .sclk(sclk_m), .sdata(sdata_m));

   initial begin
      CLK_SYS = 1'b0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
         error_cnt++;
      end
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
         error_cnt++;
      end
   endtask

   task automatic cycles(input int c);
      repeat (c) @(negedge CLK_SYS);
   endtask

   // mux bits: clock, counter wave, data out, freq bit2, freq bit5, status
   task automatic mux_case(input logic [5:0] m, input logic [5:0] dir, input int idx,
         input logic exp, input logic use_val);
      MUX = mux_cfg_t'(m);
      PIN_DIRECTION = dir;
      cycles(3);
      if (use_val) chk_bit(PIN_OUT[idx], exp);
      chk_bit(PIN_OE[idx], dir[idx]);
   endtask

   task automatic start_write();
      START_WRITE = 1'b1;
      START_VALUE = 1'b1;
      cycles(1);
      START_WRITE = 1'b0;
      cycles(1);
   endtask

   task automatic take_rx();
      RX_READY = 1'b1;
      cycles(1);
      RX_READY = 1'b0;
   endtask

   task automatic xfer(input logic msb, input logic edge_sel, input logic mask,
         input logic retime, input logic use_write);
      logic [7:0] rxb, exp_tx, got;
      int w;
      rxb = $urandom;
      CFG = '{SRC_SLAVE, edge_sel, msb, retime};
      IRQ_MASK = mask;
      if (use_write) begin
         DATA_IN = $urandom;
         exp_tx = DATA_IN;
         DATA_WRITE = 1'b1;
         cycles(1);
         DATA_WRITE = 1'b0;
      end else begin
         exp_tx = tx_q.pop_front();
      end
      start_write();
      chk_bit(TRANSFER_DONE_IRQ, 1'b0);
      chk_bit(START, 1'b1);
      chk_bit(PIN_OUT[3], 1'b1);
      u_serial_master_model.frame(rxb, msb, got);
      for (w = 0; w < 20 && RX_VALID !== 1'b1; w++) cycles(1);
      if (w == 20) begin
         error_cnt++;
         complete_run();
      end
      cycles(2);
      chk_bit(START, 1'b0);
      chk_byte(RX_DATA, rxb);
      chk_byte({DATA_HIGH, DATA_LOW}, rxb);
      if (!retime) chk_byte(got, exp_tx);
      chk_bit(TRANSFER_DONE_IRQ, ~mask);
      chk_bit(PIN_OUT[3], STATUS);
      take_rx();
   endtask

   initial begin
      RESETN = 1'b0;
      {SLEEP, EXT_CLOCK_USED, START_WRITE, START_VALUE, STATUS} = 5'h00;
      {IRQ_MASK, DATA_WRITE, TX_VALID, RX_READY} = 4'h0;
      FREQ_SELECT = FOUT_1HZ;
      CFG = '0;
      MUX = '0;
      PIN_DIRECTION = 6'h00;
      DATA_IN = 8'h00;
      TX_DATA = 8'h00;
      i = $urandom(79053);
      {RC_CLOCK, COUNTER_WAVE, PRESCALER_2KHZ, PRESCALER_1HZ, PRESCALER_8KHZ} = $urandom;
      GENERAL_OUTPUT_LATCH = $urandom;
      pin_rest = $urandom;
      cycles(5);
      chk_bit(PIN_OUT[2], 1'b1);
      chk_bit(PIN_OE[2], 1'b1);
      RESETN = 1'b1;
      cycles(2);
      chk_bit(START, 1'b0);
      chk_byte({DATA_HIGH, DATA_LOW}, DATA_RESET);
      chk_byte({2'h0, PIN_OE}, 8'h00);
      $display("test reset done");
      mux_case(6'b000000, 6'h02, PB1, GENERAL_OUTPUT_LATCH[1], 1'b1);
      mux_case(6'b010000, 6'h02, PB1, COUNTER_WAVE, 1'b1);
      mux_case(6'b110000, 6'h02, PB1, 1'b0, 1'b1);
      mux_case(6'b000000, 6'h04, PB2, GENERAL_OUTPUT_LATCH[2], 1'b1);
      FREQ_SELECT = FOUT_2KHZ;
      mux_case(6'b000100, 6'h04, PB2, PRESCALER_2KHZ, 1'b1);
      mux_case(6'b001100, 6'h04, PB2, PRESCALER_8KHZ, 1'b1);
      mux_case(6'b001100, 6'h00, PB2, 1'b0, 1'b0);
      SLEEP = 1'b1;
      mux_case(6'b001100, 6'h04, PB2, 1'b0, 1'b1);
      SLEEP = 1'b0;
      mux_case(6'b000000, 6'h08, PB3, GENERAL_OUTPUT_LATCH[3], 1'b1);
      STATUS = 1'b1;
      mux_case(6'b000001, 6'h08, PB3, 1'b1, 1'b1);
      STATUS = 1'b0;
      mux_case(6'b000000, 6'h20, PB5, GENERAL_OUTPUT_LATCH[5], 1'b1);
      for (i = 0; i < 4; i++) begin
         FREQ_SELECT = 2'(i);
         mux_case(6'b000010, 6'h20, PB5, i == 0 ? PRESCALER_1HZ : i == 1 ? PRESCALER_2KHZ :
            RC_CLOCK, i != 2);
      end
      EXT_CLOCK_USED = 1'b1;
      mux_case(6'b000010, 6'h20, PB5, sclk_m, 1'b1);
      $display("test pin mux done");
      MUX = mux_cfg_t'(6'b001001);
      PIN_DIRECTION = 6'h0C;
      u_serial_master_model.frame(8'hA5, 1'b0, DATA_IN);
      cycles(3);
      chk_bit(RX_VALID, 1'b0);
      chk_byte({DATA_HIGH, DATA_LOW}, DATA_RESET);
      TX_VALID = 1'b1;
      for (n = 0; n < 20; n++) begin
         TX_DATA = $urandom;
         if (TX_READY !== 1'b1) break;
         tx_q.push_back(TX_DATA);
         cycles(1);
      end
      TX_VALID = 1'b0;
      chk_byte(8'(n), 8'(FIFO_DEPTH));
      for (i = 0; i < FIFO_DEPTH; i++) begin
         STATUS = (i == 7);
         xfer(i[0], i == 5, i == 3, i == 9, 1'b0);
      end
      xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
      $display("test slave transfers done");
      MUX = mux_cfg_t'(6'b101001);
      PIN_DIRECTION = 6'h0E;
      for (i = 1; i < 4; i++) begin
         CFG = '{2'(i), 1'b0, 1'b0, 1'b0};
         start_write();
         n = 0;
         for (w = 0; w < 300 && TRANSFER_DONE_IRQ !== 1'b1; w++) begin
            logic prev;
            prev = PIN_OUT[1];
            cycles(1);
            if (prev === 1'b1 && PIN_OUT[1] === 1'b0) n++;
         end
         if (w == 300) begin
            error_cnt++;
            complete_run();
         end
         chk_byte(8'(n), 8'(SHIFT_COUNT));
         cycles(2);
         chk_bit(PIN_OUT[1], 1'b0);
         take_rx();
      end
      $display("test master transfers done");
      complete_run();
   end
endmodule // serial_port_bench
